// >>> design/tsq_sequencer.sv
/*
 Trigger sequencer for a two-channel source/measure instrument: arm and
 trigger layers per channel and action, timers, delays, output triggers.
 Assumes synchronous trigger inputs and an AHB-Lite master on hclk.
*/
// The placing of the registers and register access over AHB-Lite were left to the implementer.
// Notes on behaviour
// [R1] Separate trigger settings for channel one and two, chosen by select.
// [R2] Arm layer, trigger layer and device action are the three targets.
// [R3] Action target takes only the output-trigger setting; rest ignored.
// [R4] Transient and acquire each keep their own layer settings.
// [R5] Layer count is 1 to 100000, or unlimited.
// [R6] Bypass skips the event wait on the first pass only.
// [R7] Source: auto, bus, timer, line one/two, network, pins 1-14.
// [R8] Timer fires repeatedly at its period, 20 or 10 us to 100000 s; the 32-bit period write reaches only 4294967295 us.
// [R9] Each layer delays 0 to 100000 s after its event; the 32-bit delay write reaches only 4294967295 us.
// [R10] Enabled output trigger pulses on each state change of the target.
// [R11] Output goes to line one/two, network, or one pin 1-14.
// [R12] Remote controller supplies bus events by trigger command.
// [R13] Auto source picks the source suited to the operating mode.
// [R14] Single-view values replace overlapping detailed settings.
// [R15] Pin function and polarity are set elsewhere before output use.
// [R16] Initiate arms, abort idles, immediate fires the layer event.
// [R17] Layer returns to idle after its count; unlimited cycles forever.
`timescale 1ns/1ps
module tsq_sequencer #(
	parameter logic FAST_VARIANT = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic internal_trigger_line_one_in,
	input wire logic internal_trigger_line_two_in,
	input wire logic network_trigger_in,
	input wire logic [13:0] digital_pin_trigger_in,
	input wire logic auto_is_timer,
	input wire logic [1:0] single_view_en,
	input wire logic [16:0] single_view_count,
	output logic internal_trigger_line_one_out,
	output logic internal_trigger_line_two_out,
	output logic network_trigger_out,
	output logic [13:0] digital_pin_trigger_out,
	output logic [3:0] action_busy
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Layer index: {ch, act, layer}, layer 0 arm, 1 trigger
	typedef struct packed {
		logic [4:0] select;
		logic [7:0][16:0] count;
		logic [7:0] unlim;
		logic [7:0] bypass;
		logic [7:0][4:0] source;
		logic [7:0][36:0] period;
		logic [7:0][36:0] delay;
		logic [11:0] out_en;
		logic [11:0][4:0] out_dst;
		logic single_en;
		logic [7:0][1:0] state;
		logic [7:0][16:0] pass;
		logic [7:0] first;
		logic [7:0][43:0] tmr;
		logic [7:0][43:0] dly;
		logic [11:0][1:0] last;
		logic aph;
		logic awr;
		logic [7:0] aaddr;
		logic [31:0] rdata;
		logic [16:0] out_pulse;
	} tsq_regs_t;
	tsq_regs_t s_q, s_d;

	function automatic logic [43:0] us_to_cyc(input logic [36:0] us);
		us_to_cyc = {7'h00, us} * 44'(tsq_pkg::US_CYCLES);
	endfunction

	function automatic logic [36:0] clamp_time(input logic [31:0] v,
			input logic [36:0] lo);
		logic [36:0] t;
		t = {5'h00, v};
		if (t < lo) begin
			clamp_time = lo;
		end else if (t > tsq_pkg::TIME_MAX_US) begin
			clamp_time = tsq_pkg::TIME_MAX_US;
		end else begin
			clamp_time = t;
		end
	endfunction

	function automatic logic src_hit(input logic [4:0] src,
			input logic tmr_evt, input logic bus_evt, input logic line1,
			input logic line2, input logic net, input logic [13:0] pins,
			input logic auto_tmr);
		logic [4:0] eff;
		eff = src;
		if (src == tsq_pkg::SRC_AUTO) begin
			eff = auto_tmr ? tsq_pkg::SRC_TIMER : tsq_pkg::SRC_BUS; // [R13]
		end
		src_hit = 1'b0;
		if (eff == tsq_pkg::SRC_BUS) begin
			src_hit = bus_evt; // [R12]
		end else if (eff == tsq_pkg::SRC_TIMER) begin
			src_hit = tmr_evt;
		end else if (eff == tsq_pkg::SRC_LINE1) begin
			src_hit = line1;
		end else if (eff == tsq_pkg::SRC_LINE2) begin
			src_hit = line2;
		end else if (eff == tsq_pkg::SRC_NET) begin
			src_hit = net;
		end else if (eff >= tsq_pkg::SRC_PIN1 && eff <= tsq_pkg::SRC_PIN14) begin
			src_hit = pins[4'(eff - tsq_pkg::SRC_PIN1)];
		end
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] li;
		logic [3:0] oi;
		logic [1:0] tgt;
		logic [7:0] a;
		logic [3:0] init_v, abort_v, busv, imm_a, imm_t, done_arm;
		logic [7:0] hit, tmr_evt, imm;
		logic [16:0] cnt;
		logic [11:0][1:0] now;
		li = '0;
		oi = '0;
		a = haddr[7:0];
		cnt = '0;
		init_v = '0;
		abort_v = '0;
		busv = '0;
		imm_a = '0;
		imm_t = '0;
		done_arm = '0;
		hit = '0;
		tmr_evt = '0;
		imm = '0;
		now = '0;
		s_d = s_q;
		s_d.out_pulse = '0;
		tgt = s_q.select[tsq_pkg::SEL_TGT_LO +: 2];
		li = {s_q.select[tsq_pkg::SEL_CH], s_q.select[tsq_pkg::SEL_ACT],
			tgt[0]}; // [R1] [R4]
		oi = {1'b0, s_q.select[tsq_pkg::SEL_CH],
			s_q.select[tsq_pkg::SEL_ACT]} * 4'h3 + {2'h0, tgt}; // [R2]
		// Bus address phase; read data is registered to stand in data phase
		if (hsel && hready && htrans[1]) begin
			s_d.aph = 1'b1;
			s_d.awr = hwrite;
			s_d.aaddr = haddr[7:0];
			if (!hwrite) begin
				s_d.rdata = '0;
				if (a == tsq_pkg::ADDR_SELECT) begin
					s_d.rdata = {27'h0, s_q.select};
				end else if (a == tsq_pkg::ADDR_COUNT) begin
					s_d.rdata = {s_q.unlim[li], 14'h0, s_q.count[li]};
				end else if (a == tsq_pkg::ADDR_SOURCE) begin
					s_d.rdata = {23'h0, s_q.bypass[li], 3'h0, s_q.source[li]};
				end else if (a == tsq_pkg::ADDR_PERIOD) begin
					s_d.rdata = s_q.period[li][31:0];
				end else if (a == tsq_pkg::ADDR_DELAY) begin
					s_d.rdata = s_q.delay[li][31:0];
				end else if (a == tsq_pkg::ADDR_OUTPUT) begin
					s_d.rdata = {23'h0, s_q.out_en[oi], 3'h0, s_q.out_dst[oi]};
				end else if (a == tsq_pkg::ADDR_STATUS) begin
					for (int i = 0; i < 8; i++) begin
						s_d.rdata[2*i +: 2] = s_q.state[i];
					end
				end else if (a == tsq_pkg::ADDR_SINGLE) begin
					s_d.rdata = {31'h0, s_q.single_en};
				end
			end
		end else if (hready) begin
			s_d.aph = 1'b0;
		end
		// Bus data phase
		if (s_q.aph && s_q.awr) begin
			a = s_q.aaddr;
			// Layer fields ignored for the action target [R3]
			if (a == tsq_pkg::ADDR_SELECT) begin
				s_d.select = hwdata[4:0];
			end else if (a == tsq_pkg::ADDR_COUNT && tgt != tsq_pkg::TGT_ACTION) begin
				cnt = hwdata[16:0];
				if (cnt < tsq_pkg::COUNT_MIN) cnt = tsq_pkg::COUNT_MIN;
				if (cnt > tsq_pkg::COUNT_MAX) cnt = tsq_pkg::COUNT_MAX;
				s_d.count[li] = cnt; // [R5]
				s_d.unlim[li] = hwdata[tsq_pkg::COUNT_UNLIM];
			end else if (a == tsq_pkg::ADDR_SOURCE && tgt != tsq_pkg::TGT_ACTION) begin
				if (hwdata[4:0] <= tsq_pkg::SRC_PIN14) begin
					s_d.source[li] = hwdata[4:0]; // [R7]
				end
				s_d.bypass[li] = hwdata[tsq_pkg::SRC_BYPASS];
			end else if (a == tsq_pkg::ADDR_PERIOD && tgt != tsq_pkg::TGT_ACTION) begin
				s_d.period[li] = clamp_time(hwdata, FAST_VARIANT ?
					tsq_pkg::PERIOD_MIN_FAST_US : tsq_pkg::PERIOD_MIN_US); // [R8]
			end else if (a == tsq_pkg::ADDR_DELAY && tgt != tsq_pkg::TGT_ACTION) begin
				s_d.delay[li] = clamp_time(hwdata, 37'h0); // [R9]
			end else if (a == tsq_pkg::ADDR_OUTPUT) begin
				if (hwdata[4:0] <= tsq_pkg::DST_PIN14) begin
					s_d.out_dst[oi] = hwdata[4:0]; // [R11]
				end
				s_d.out_en[oi] = hwdata[tsq_pkg::OUT_EN];
			end else if (a == tsq_pkg::ADDR_COMMAND) begin
				oi = {2'h0, hwdata[tsq_pkg::CMD_CH], hwdata[tsq_pkg::CMD_ACT]};
				init_v[oi[1:0]] = hwdata[tsq_pkg::CMD_INIT];
				abort_v[oi[1:0]] = hwdata[tsq_pkg::CMD_ABORT];
				imm_a[oi[1:0]] = hwdata[tsq_pkg::CMD_IMM_ARM];
				imm_t[oi[1:0]] = hwdata[tsq_pkg::CMD_IMM_TRIG];
				busv[oi[1:0]] = hwdata[tsq_pkg::CMD_BUS];
			end else if (a == tsq_pkg::ADDR_SINGLE) begin
				s_d.single_en = hwdata[tsq_pkg::SGL_EN];
			end
		end
		// Timers and event detection
		for (int i = 0; i < 8; i++) begin
			if (s_q.state[i] == tsq_pkg::ST_IDLE ||
					s_q.tmr[i] == '0) begin
				s_d.tmr[i] = us_to_cyc(s_q.period[i]) - 44'h1;
				tmr_evt[i] = s_q.state[i] != tsq_pkg::ST_IDLE; // [R8]
			end else begin
				s_d.tmr[i] = s_q.tmr[i] - 44'h1;
			end
			imm[i] = i[0] ? imm_t[i[2:1]] : imm_a[i[2:1]];
			hit[i] = imm[i] || src_hit(s_q.source[i], tmr_evt[i],
				busv[i[2:1]], internal_trigger_line_one_in,
				internal_trigger_line_two_in, network_trigger_in,
				digital_pin_trigger_in, auto_is_timer); // [R16]
		end
		// Layer machines: arm (even) then trigger (odd)
		for (int i = 0; i < 8; i++) begin
			cnt = (s_q.single_en && single_view_en[i[0]]) ?
				single_view_count : s_q.count[i]; // [R14]
			unique case (s_q.state[i])
				tsq_pkg::ST_IDLE: begin
					if ((i[0] == 1'b0 && init_v[i[2:1]]) ||
							(i[0] == 1'b1 && s_q.state[i-1] == tsq_pkg::ST_DELAY &&
							s_q.dly[i-1] == '0 && !done_arm[i[2:1]])) begin
						s_d.state[i] = tsq_pkg::ST_WAIT; // [R16]
						s_d.pass[i] = '0;
						s_d.first[i] = 1'b1;
					end
				end
				tsq_pkg::ST_WAIT: begin
					if (hit[i] || (s_q.first[i] && s_q.bypass[i])) begin // [R6]
						s_d.state[i] = tsq_pkg::ST_DELAY;
						s_d.first[i] = 1'b0;
						s_d.dly[i] = us_to_cyc(s_q.delay[i]); // [R9]
					end
				end
				tsq_pkg::ST_DELAY: begin
					if (s_q.dly[i] != '0) begin
						s_d.dly[i] = s_q.dly[i] - 44'h1;
					end else if (i[0] == 1'b0) begin
						// Arm hands over to trigger and waits for it to finish
						s_d.state[i] = tsq_pkg::ST_DELAY;
						if (s_q.state[i+1] == tsq_pkg::ST_IDLE &&
								s_q.last[{1'b0, i[2:1], 1'b0} * 3 / 2 + 1] !=
								tsq_pkg::ST_IDLE) begin
							done_arm[i[2:1]] = 1'b1;
						end
					end else begin
						s_d.pass[i] = s_q.pass[i] + 17'h1;
						if (!s_q.unlim[i] && s_q.pass[i] + 17'h1 >= cnt) begin
							s_d.state[i] = tsq_pkg::ST_IDLE; // [R17]
						end else begin
							s_d.state[i] = tsq_pkg::ST_WAIT; // [R5]
						end
					end
				end
				default: s_d.state[i] = tsq_pkg::ST_IDLE;
			endcase
		end
		// Arm pass accounting once its trigger layer has finished
		for (int i = 0; i < 8; i += 2) begin
			cnt = (s_q.single_en && single_view_en[0]) ?
				single_view_count : s_q.count[i];
			if (done_arm[i/2]) begin
				s_d.pass[i] = s_q.pass[i] + 17'h1;
				if (!s_q.unlim[i] && s_q.pass[i] + 17'h1 >= cnt) begin
					s_d.state[i] = tsq_pkg::ST_IDLE; // [R17]
				end else begin
					s_d.state[i] = tsq_pkg::ST_WAIT;
				end
			end
			if (abort_v[i/2]) begin
				s_d.state[i] = tsq_pkg::ST_IDLE; // [R16]
				s_d.state[i+1] = tsq_pkg::ST_IDLE;
			end
		end
		// Output triggers on state change of arm, trigger, action
		for (int g = 0; g < 4; g++) begin
			now[3*g] = s_q.state[2*g];
			now[3*g+1] = s_q.state[2*g+1];
			now[3*g+2] = (s_q.state[2*g] != tsq_pkg::ST_IDLE) ?
				tsq_pkg::ST_WAIT : tsq_pkg::ST_IDLE;
		end
		for (int t = 0; t < 12; t++) begin
			s_d.last[t] = now[t];
			if (s_q.out_en[t] && now[t] != s_q.last[t]) begin // [R10]
				s_d.out_pulse[s_q.out_dst[t]] = 1'b1; // [R11]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			for (int i = 0; i < 8; i++) begin
				s_q.count[i] <= tsq_pkg::COUNT_RESET;
				s_q.period[i] <= tsq_pkg::PERIOD_MIN_US;
			end
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign internal_trigger_line_one_out = s_q.out_pulse[tsq_pkg::DST_LINE1];
	assign internal_trigger_line_two_out = s_q.out_pulse[tsq_pkg::DST_LINE2];
	assign network_trigger_out = s_q.out_pulse[tsq_pkg::DST_NET];
	assign digital_pin_trigger_out = s_q.out_pulse[tsq_pkg::DST_PIN14:
		tsq_pkg::DST_PIN1]; // [R15]
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			action_busy[g] = s_q.state[2*g] != tsq_pkg::ST_IDLE;
		end
	end
endmodule

// >>> shared/tsq_pkg.sv
/*
 Constants and types for the trigger sequencer: register map, field
 layouts, event source and output destination codes, timing counts.
 Assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
*/
package tsq_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SELECT = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_SOURCE = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0c;
	localparam logic [7:0] ADDR_DELAY = 8'h10;
	localparam logic [7:0] ADDR_OUTPUT = 8'h14;
	localparam logic [7:0] ADDR_COMMAND = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_SINGLE = 8'h20;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SEL_CH = 0;
	localparam int SEL_ACT = 1;
	localparam int SEL_TGT_LO = 2;
	localparam int COUNT_UNLIM = 31;
	localparam int SRC_BYPASS = 8;
	localparam int OUT_EN = 8;
	localparam int CMD_INIT = 0;
	localparam int CMD_ABORT = 1;
	localparam int CMD_IMM_ARM = 2;
	localparam int CMD_IMM_TRIG = 3;
	localparam int CMD_BUS = 4;
	localparam int CMD_CH = 8;
	localparam int CMD_ACT = 9;
	localparam int SGL_EN = 0;
	// ----------------------------------------------------------------
	// Targets, sources, destinations
	// ----------------------------------------------------------------
	localparam logic [1:0] TGT_ARM = 2'h0;
	localparam logic [1:0] TGT_TRIG = 2'h1;
	localparam logic [1:0] TGT_ACTION = 2'h2;
	localparam logic [4:0] SRC_AUTO = 5'h00;
	localparam logic [4:0] SRC_BUS = 5'h01;
	localparam logic [4:0] SRC_TIMER = 5'h02;
	localparam logic [4:0] SRC_LINE1 = 5'h03;
	localparam logic [4:0] SRC_LINE2 = 5'h04;
	localparam logic [4:0] SRC_NET = 5'h05;
	localparam logic [4:0] SRC_PIN1 = 5'h06;
	localparam logic [4:0] SRC_PIN14 = 5'h13;
	localparam logic [4:0] DST_LINE1 = 5'h00;
	localparam logic [4:0] DST_LINE2 = 5'h01;
	localparam logic [4:0] DST_NET = 5'h02;
	localparam logic [4:0] DST_PIN1 = 5'h03;
	localparam logic [4:0] DST_PIN14 = 5'h10;
	localparam int PIN_COUNT = 14;
	// ----------------------------------------------------------------
	// Counts and timing (period and delay are held in microseconds)
	// ----------------------------------------------------------------
	localparam logic [16:0] COUNT_MIN = 17'h00001;
	localparam logic [16:0] COUNT_MAX = 17'h186a0;
	localparam logic [16:0] COUNT_RESET = 17'h00001;
	localparam int CLK_MHZ = 100;
	localparam int US_CYCLES = CLK_MHZ;
	localparam logic [36:0] PERIOD_MIN_US = 37'h0000000014;
	localparam logic [36:0] PERIOD_MIN_FAST_US = 37'h000000000a;
	localparam logic [36:0] TIME_MAX_US = 37'h174876e800;
	// ----------------------------------------------------------------
	// Layer state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DELAY = 2'b11
	} tsq_state_t;
endpackage

// >>> verification/trigger_sequencer_config_test.sv
/*
 Self-checking bench for the trigger sequencer.
 Assumes the AHB-Lite register map and status layout of tsq_pkg.
*/
`timescale 1ns/1ps
module trigger_sequencer_config_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd_q;
	logic hready, hresp, o1, o2, on, l1, l2, nt;
	logic [13:0] op, pins;
	logic [3:0] busy;
	logic [16:0] req = 17'h0;
	logic [16:0] seen = 17'h0;
	logic clr = 1'b0;
	logic auto_tmr = 1'b0;
	logic [1:0] sv_en = 2'h0;
	logic [16:0] sv_cnt = 17'h2;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	always #5 hclk = ~hclk;
	tsq_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp),
		.internal_trigger_line_one_in(l1), .internal_trigger_line_two_in(l2),
		.network_trigger_in(nt), .digital_pin_trigger_in(pins),
		.auto_is_timer(auto_tmr), .single_view_en(sv_en),
		.single_view_count(sv_cnt), .internal_trigger_line_one_out(o1),
		.internal_trigger_line_two_out(o2), .network_trigger_out(on),
		.digital_pin_trigger_out(op), .action_busy(busy));
	tsq_event_source partner (.req(req), .internal_trigger_line_one(l1),
		.internal_trigger_line_two(l2), .net(nt), .digital_pin_trigger(pins));
	always @(posedge hclk) begin
		rd_q <= hrdata;
		seen <= clr ? 17'h0 : seen | {op, on, o2, o1};
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			print_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("checked %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		#1 r = rd_q;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask
	task automatic cfg(input logic [31:0] s, c, src, dl);
		wr(tsq_pkg::ADDR_SELECT, s);
		wr(tsq_pkg::ADDR_COUNT, c);
		wr(tsq_pkg::ADDR_SOURCE, src);
		wr(tsq_pkg::ADDR_DELAY, dl);
	endtask
	task automatic fire(input int i);
		@(posedge hclk);
		req <= 17'h1 << i;
		@(posedge hclk);
		req <= 17'h0;
	endtask
	task automatic poll(input string n, input logic [31:0] m, e);
		logic [31:0] r;
		for (int k = 0; k < 200; k++) begin
			rd(tsq_pkg::ADDR_STATUS, r);
			if ((r & m) === e) break;
		end
		chk(n, r & m, e);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] r;
		cfg(32'h1, 32'h0, 32'h0, 32'h0);
		rd(tsq_pkg::ADDR_COUNT, r);
		chk("count low clamp", r, 32'h1);
		wr(tsq_pkg::ADDR_COUNT, 32'h1ffff);
		rd(tsq_pkg::ADDR_COUNT, r);
		chk("count high clamp", r, 32'h186a0);
		wr(tsq_pkg::ADDR_SELECT, 32'h2);
		rd(tsq_pkg::ADDR_COUNT, r);
		chk("acquire count", r, 32'h1);
		wr(tsq_pkg::ADDR_SELECT, 32'h8);
		wr(tsq_pkg::ADDR_COUNT, 32'h5);
		wr(tsq_pkg::ADDR_SELECT, 32'h0);
		rd(tsq_pkg::ADDR_COUNT, r);
		chk("channel one count", r, 32'h1);
		rd(8'h24, r);
		chk("unmapped", r, 32'h0);
	endtask
	task automatic t_seq();
		cfg(32'h0, 32'h1, tsq_pkg::SRC_LINE1, 32'h0);
		cfg(32'h4, 32'h2, tsq_pkg::SRC_NET, 32'h1);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		chk("armed", busy, 4'h1);
		poll("arm wait", 32'hf, 32'h1);
		fire(0);
		poll("trig wait", 32'hc, 32'h4);
		fire(2);
		poll("trig delay", 32'hc, 32'hc);
		poll("trig again", 32'hc, 32'h4);
		fire(2);
		poll("done", 32'hf, 32'h0);
	endtask
	task automatic t_bypass();
		cfg(32'h0, 32'h2, 32'h100 | tsq_pkg::SRC_LINE2, 32'h0);
		cfg(32'h4, 32'h1, tsq_pkg::SRC_AUTO, 32'h0);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		poll("bypass first", 32'hc, 32'h4);
		wr(tsq_pkg::ADDR_COMMAND, 32'h10);
		poll("second pass", 32'hf, 32'h1);
		fire(1);
		poll("line two", 32'hc, 32'h4);
		wr(tsq_pkg::ADDR_COMMAND, 32'h10);
		poll("arm count", 32'hf, 32'h0);
	endtask
	task automatic t_imm();
		cfg(32'h0, 32'h1, tsq_pkg::SRC_PIN1, 32'h0);
		cfg(32'h4, 32'h1, tsq_pkg::SRC_PIN14, 32'h0);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		fire(3);
		poll("pin one", 32'hc, 32'h4);
		wr(tsq_pkg::ADDR_COMMAND, 32'h8);
		poll("immediate trig", 32'hf, 32'h0);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		wr(tsq_pkg::ADDR_COMMAND, 32'h4);
		poll("immediate arm", 32'hc, 32'h4);
		wr(tsq_pkg::ADDR_COMMAND, 32'h2);
		chk("aborted", busy, 4'h0);
	endtask
	task automatic t_out();
		wr(tsq_pkg::ADDR_SELECT, 32'h8);
		// Pin function is taken as set up elsewhere before the pin is used as a target
		wr(tsq_pkg::ADDR_OUTPUT, 32'h100 | (tsq_pkg::DST_PIN1 + 5'h2));
		@(posedge hclk) clr <= 1'b1;
		@(posedge hclk) clr <= 1'b0;
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		for (int k = 0; k < 20 && seen == 17'h0; k++) @(posedge hclk);
		chk("pin three out", seen, 32'h20);
		wr(tsq_pkg::ADDR_COMMAND, 32'h2);
		wr(tsq_pkg::ADDR_OUTPUT, 32'h0);
	endtask
	task automatic t_timer();
		int n;
		int p;
		p = tsq_pkg::US_CYCLES * 20;
		cfg(32'h0, 32'h1, 32'h100, 32'h0);
		cfg(32'h4, 32'h2, tsq_pkg::SRC_TIMER, 32'h0);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		for (n = 0; n < 5000 && busy[0] === 1'b1; n++) @(posedge hclk);
		chk("timer span", n >= p - 5 && n <= 2 * p + 50, 32'h1);
	endtask
	task automatic t_single();
		wr(tsq_pkg::ADDR_SINGLE, 32'h1);
		sv_en <= 2'h2;
		cfg(32'h4, 32'h1, tsq_pkg::SRC_BUS, 32'h0);
		wr(tsq_pkg::ADDR_COMMAND, 32'h1);
		wr(tsq_pkg::ADDR_COMMAND, 32'h10);
		poll("single view", 32'hf, 32'h7);
		wr(tsq_pkg::ADDR_COMMAND, 32'h10);
		poll("single done", 32'hf, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_seq();
		t_bypass();
		t_imm();
		t_out();
		t_timer();
		t_single();
		print_verdict();
	end
endmodule

// >>> verification/tsq_checker_sva.sv
/*
 Checker on the trigger sequencer top ports.
 Assumes it is bound onto tsq_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module tsq_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic internal_trigger_line_one_out,
	input wire logic internal_trigger_line_two_out,
	input wire logic network_trigger_out,
	input wire logic [13:0] digital_pin_trigger_out,
	input wire logic [3:0] action_busy
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic cw_q, ur_q, any_out;
	logic [3:0] busy_q, bh_q;
	logic [1:0] ih_q;
	assign any_out = internal_trigger_line_one_out |
		internal_trigger_line_two_out | network_trigger_out |
		(|digital_pin_trigger_out);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cw_q <= 1'b0;
			ur_q <= 1'b0;
			busy_q <= 4'h0;
			bh_q <= 4'h0;
			ih_q <= 2'h0;
		end else begin
			cw_q <= hsel & hready & htrans[1] & hwrite & (haddr == 32'h18);
			ur_q <= hsel & hready & htrans[1] & !hwrite & (haddr > 32'h20);
			busy_q <= action_busy;
			bh_q <= {bh_q[2:0], |action_busy};
			ih_q <= {ih_q[0], cw_q & hwdata[0]};
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_resp; !hresp; endproperty
	a_resp: assert property (p_resp) else $error("error resp");
	property p_rst_idle;
		!$past(hresetn) |-> action_busy == 4'h0 && !any_out;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle");
	property p_init;
		cw_q && hwdata[1:0] == 2'b01 && hwdata[9:8] == 2'b00
			|-> ##[1:3] action_busy[0];
	endproperty
	a_init: assert property (p_init) else $error("init no arm");
	property p_abort;
		cw_q && hwdata[1] && hwdata[9:8] == 2'b00 |-> ##[1:3] !action_busy[0];
	endproperty
	a_abort: assert property (p_abort) else $error("abort no idle");
	property p_rise;
		|(action_busy & ~busy_q) |-> (cw_q && hwdata[0]) || ih_q != 2'h0;
	endproperty
	a_rise: assert property (p_rise) else $error("busy uncaused");
	property p_unmap; ur_q |-> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	property p_quiet; any_out |-> (|action_busy) || bh_q != 4'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("stray trigger");
endmodule
bind tsq_sequencer tsq_checker u_chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
	.internal_trigger_line_one_out, .internal_trigger_line_two_out,
	.network_trigger_out, .digital_pin_trigger_out, .action_busy);

// >>> verification/tsq_event_source.sv
/*
 Far-side model: internal lines, network trigger and digital pins.
 Assumes the bench raises req bits for one cycle after a clock edge.
*/
`timescale 1ns/1ps
module tsq_event_source (
	input wire logic [16:0] req,
	output logic internal_trigger_line_one,
	output logic internal_trigger_line_two,
	output logic net,
	output logic [13:0] digital_pin_trigger
);
	// Lines rest low and pulse only while requested
	assign {digital_pin_trigger, net, internal_trigger_line_two,
		internal_trigger_line_one} = req;
endmodule
